// ===== verilog/uwk_pkg.sv
// Purpose : shared constants and types of the usb remote wakeup block
// Assumes : pclk at 250 MHz, apb register access with 32-bit data
// Notes   : times are kept in their own unit, cycle counts derived
package uwk_pkg;

    // clock
    localparam int CLK_MHZ       = 250;
    localparam int CLK_PERIOD_NS = 4;

    // line times
    localparam int T_SUSPEND_US  = 3000;
    localparam int T_WAKE_US     = 5000;
    localparam int T_KDRIVE_US   = 2000;
    localparam int T_BUSRST_NS   = 2500;

    // derived cycle counts, least times rounded up
    localparam int SUSPEND_CYC   = T_SUSPEND_US * CLK_MHZ;
    localparam int WAKE_CYC      = T_WAKE_US * CLK_MHZ;
    localparam int KDRIVE_CYC    = T_KDRIVE_US * CLK_MHZ;
    localparam int BUSRST_CYC    =
        (T_BUSRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles our own K stays visible through the line synchroniser
    localparam int ECHO_CYC      = 3;

    // widths
    localparam int TMR_W         = 21;
    localparam int ADDR_W        = 8;
    localparam int REG_W         = 8;
    localparam int CFG_W         = 3;
    localparam int SYNC_W        = 28;

    // register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_DEV_STATE  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_INT_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_INT_CLEAR  = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_BUS_CFG    = 8'h10;

    // device_state_register fields
    localparam int DS_SUSPENDED  = 0;
    localparam int DS_DRIVING    = 1;
    localparam int DS_WAKE_REQ   = 4;

    // interrupt_status_register fields
    localparam int IS_WAKE_DONE  = 4;
    localparam int IS_BUS_RESET  = 5;
    localparam int IS_SUSPEND    = 6;

    // bus configuration fields
    localparam int CFG_MUX       = 0;
    localparam int CFG_DMA16     = 1;
    localparam int CFG_OSC_STOP  = 2;

    // line states as {dp, dm}
    localparam logic [1:0] LINE_J   = 2'h2;
    localparam logic [1:0] LINE_K   = 2'h1;
    localparam logic [1:0] LINE_SE0 = 2'h0;

    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        UWK_ACTIVE      = 2'b00,
        UWK_SUSPEND     = 2'b01,
        UWK_DRIVE_K     = 2'b10,
        UWK_WAIT_RESUME = 2'b11
    } uwk_state_e;

endpackage

// ===== verilog/uwk_sync.sv
// Purpose : two flip-flop synchroniser for asynchronous pins
// Assumes : each bit is an independent level
// Notes   : first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module uwk_sync
    import uwk_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // pins in, synchronised out
    input  wire logic [SYNC_W-1:0] din,
    output logic      [SYNC_W-1:0] dout
);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
    } uwk_sync_s;

    uwk_sync_s st_reg;
    uwk_sync_s st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2;

endmodule
`default_nettype wire

// ===== verilog/uwk_line_timer.sv
// Purpose : counts cycles while a line condition holds
// Assumes : condition already synchronised to pclk
// Notes   : saturates at all ones, clears when condition drops
`timescale 1ns/1ps
`default_nettype none
module uwk_line_timer
    import uwk_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // condition and elapsed count
    input  wire logic             hold,
    output logic      [TMR_W-1:0] count
);

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
    } uwk_tmr_s;

    uwk_tmr_s st_reg;
    uwk_tmr_s st_next;

    always_comb begin
        st_next = st_reg;
        if (!hold) begin
            st_next.cnt = '0;
        end else if (st_reg.cnt != '1) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count = st_reg.cnt;

endmodule
`default_nettype wire

// ===== verilog/uwk_remote_wakeup_ctrl.sv
// Purpose : usb suspend, remote wakeup and host bus pin selection
// Assumes : usb full speed line, pins asynchronous to pclk
// Notes   : apb reads are sampled in the setup cycle
//
// Contract
// - wakeup acted on only while suspended
// - request early: wait for 5 ms idle
// - idle already past 5 ms: drive at once
// - host resume after wakeup clears request bit
// - no wakeup while oscillator is stopped
// - multiplexed mode ignores separate address inputs
// - separate mode ignores address latch strobe
// - eight-bit dma ignores upper data byte
// - idle 3 ms enters suspend
// - resume or reset clears suspend status
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uwk_remote_wakeup_ctrl
    import uwk_pkg::*;
#(
    parameter int unsigned SUSPEND_CYC_P = SUSPEND_CYC,
    parameter int unsigned WAKE_CYC_P    = WAKE_CYC,
    parameter int unsigned KDRIVE_CYC_P  = KDRIVE_CYC
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // usb line
    input  wire logic              usb_dp_in,
    input  wire logic              usb_dm_in,
    output logic                   usb_dp_out,
    output logic                   usb_dm_out,
    output logic                   usb_oe_n,
    // host bus pins
    input  wire logic              ale,
    input  wire logic [7:0]        ad_lines,
    input  wire logic [7:0]        separate_address_inputs,
    input  wire logic [7:0]        upper_data_byte_lines,
    input  wire logic              dma_strobe,
    // captured bus values
    output logic      [7:0]        bus_addr,
    output logic      [15:0]       dma_data,
    output logic                   dma_valid,
    // interrupt
    output logic                   interrupt_request_out
);

    typedef struct packed {
        uwk_state_e       state;
        logic [TMR_W-1:0] kcnt;
        logic             wake_req;
        logic [REG_W-1:0] int_status;
        logic [REG_W-1:0] int_enable;
        logic [CFG_W-1:0] bus_cfg;
        logic             irq;
        logic             drive;
        logic             ale_q;
        logic             strb_q;
        logic             dma_valid;
        logic [7:0]       bus_addr;
        logic [15:0]      dma_data;
        logic [31:0]      prdata;
        logic             pslverr;
    } uwk_main_s;

    uwk_main_s st_reg;
    uwk_main_s st_next;

    logic [SYNC_W-1:0] sync_out;
    logic              dp_s;
    logic              dm_s;
    logic              ale_s;
    logic              strb_s;
    logic [7:0]        ad_s;
    logic [7:0]        sep_s;
    logic [7:0]        up_s;
    logic [1:0]        line;
    logic [TMR_W-1:0]  idle_cnt;
    logic [TMR_W-1:0]  se0_cnt;
    logic              bus_reset_evt;
    logic              idle_susp;
    logic              idle_wake;

    uwk_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({usb_dp_in, usb_dm_in, ale, dma_strobe, ad_lines,
                   separate_address_inputs, upper_data_byte_lines}),
        .dout    (sync_out)
    );

    assign {dp_s, dm_s, ale_s, strb_s, ad_s, sep_s, up_s} = sync_out;
    assign line = {dp_s, dm_s};

    // idle means the host leaves the line in J
    uwk_line_timer u_idle (
        .pclk    (pclk),
        .presetn (presetn),
        .hold    (line == LINE_J),
        .count   (idle_cnt)
    );

    uwk_line_timer u_se0 (
        .pclk    (pclk),
        .presetn (presetn),
        .hold    (line == LINE_SE0),
        .count   (se0_cnt)
    );

    assign bus_reset_evt = (se0_cnt == TMR_W'(BUSRST_CYC));
    assign idle_susp     = (idle_cnt >= TMR_W'(SUSPEND_CYC_P));
    assign idle_wake     = (idle_cnt >= TMR_W'(WAKE_CYC_P));

    always_comb begin
        logic [REG_W-1:0] clr;
        logic [REG_W-1:0] set;
        clr = '0;
        set = '0;
        st_next           = st_reg;
        st_next.dma_valid = 1'b0;
        st_next.ale_q     = ale_s;
        st_next.strb_q    = strb_s;

        if (st_reg.bus_cfg[CFG_MUX]) begin
            if (ale_s && !st_reg.ale_q) begin
                st_next.bus_addr = ad_s;
            end
        end else begin
            st_next.bus_addr = sep_s;
        end

        if (strb_s && !st_reg.strb_q) begin
            st_next.dma_valid = 1'b1;
            st_next.dma_data  = {st_reg.bus_cfg[CFG_DMA16] ? up_s : BYTE_ZERO,
                                 ad_s};
        end

        case (st_reg.state)
            UWK_ACTIVE: begin
                if (idle_susp) begin
                    st_next.state    = UWK_SUSPEND;
                    set[IS_SUSPEND]  = 1'b1;
                end
            end
            UWK_SUSPEND: begin
                if (line != LINE_J) begin
                    st_next.state    = UWK_ACTIVE;
                    clr[IS_SUSPEND]  = 1'b1;
                end else if (st_reg.wake_req &&
                             !st_reg.bus_cfg[CFG_OSC_STOP] && idle_wake) begin
                    st_next.state    = UWK_DRIVE_K;
                    st_next.kcnt     = '0;
                end
            end
            UWK_DRIVE_K: begin
                if (st_reg.kcnt == TMR_W'(KDRIVE_CYC_P - 1)) begin
                    st_next.state    = UWK_WAIT_RESUME;
                end else begin
                    st_next.kcnt     = st_reg.kcnt + 1'b1;
                end
            end
            UWK_WAIT_RESUME: begin
                // skip our own K still in the synchroniser
                if (st_reg.kcnt != TMR_W'(KDRIVE_CYC_P - 1 + ECHO_CYC)) begin
                    st_next.kcnt      = st_reg.kcnt + 1'b1;
                end else if (line == LINE_K) begin
                    st_next.state     = UWK_ACTIVE;
                    st_next.wake_req  = 1'b0;
                    clr[IS_SUSPEND]   = 1'b1;
                    set[IS_WAKE_DONE] = 1'b1;
                end
            end
            default: begin
                st_next.state = UWK_ACTIVE;
            end
        endcase

        if (bus_reset_evt) begin
            st_next.state     = UWK_ACTIVE;
            clr[IS_SUSPEND]   = 1'b1;
            set[IS_BUS_RESET] = 1'b1;
        end

        // read data is taken in the setup cycle
        if (psel && !penable) begin
            st_next.prdata  = WORD_ZERO;
            st_next.pslverr = 1'b0;
            if (paddr == ADDR_DEV_STATE) begin
                st_next.prdata[DS_SUSPENDED] = (st_reg.state != UWK_ACTIVE);
                st_next.prdata[DS_DRIVING]   = st_reg.drive;
                st_next.prdata[DS_WAKE_REQ]  = st_reg.wake_req;
            end else if (paddr == ADDR_INT_STATUS) begin
                st_next.prdata[REG_W-1:0] = st_reg.int_status;
            end else if (paddr == ADDR_INT_CLEAR) begin
                st_next.prdata = WORD_ZERO;
            end else if (paddr == ADDR_INT_ENABLE) begin
                st_next.prdata[REG_W-1:0] = st_reg.int_enable;
            end else if (paddr == ADDR_BUS_CFG) begin
                st_next.prdata[CFG_W-1:0] = st_reg.bus_cfg;
            end else begin
                st_next.pslverr = 1'b1;
            end
        end

        if (psel && penable && pwrite) begin
            if (paddr == ADDR_DEV_STATE) begin
                if (st_reg.state != UWK_ACTIVE) begin
                    st_next.wake_req = pwdata[DS_WAKE_REQ];
                end
            end else if (paddr == ADDR_INT_CLEAR) begin
                clr = clr | pwdata[REG_W-1:0];
            end else if (paddr == ADDR_INT_ENABLE) begin
                st_next.int_enable = pwdata[REG_W-1:0];
            end else if (paddr == ADDR_BUS_CFG) begin
                st_next.bus_cfg = pwdata[CFG_W-1:0];
            end
        end

        // a set in the clearing cycle wins
        st_next.int_status = (st_reg.int_status & ~clr) | set;
        st_next.drive      = (st_next.state == UWK_DRIVE_K);
        st_next.irq        = |(st_next.int_status & st_next.int_enable);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata                = st_reg.prdata;
    assign pslverr               = st_reg.pslverr;
    assign pready                = 1'b1;
    assign usb_dp_out            = LINE_K[1];
    assign usb_dm_out            = LINE_K[0];
    assign usb_oe_n              = !st_reg.drive;
    assign bus_addr              = st_reg.bus_addr;
    assign dma_data              = st_reg.dma_data;
    assign dma_valid             = st_reg.dma_valid;
    assign interrupt_request_out = st_reg.irq;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_wake_ready;
        st_reg.state == UWK_SUSPEND && st_reg.wake_req &&
        !st_reg.bus_cfg[CFG_OSC_STOP] && idle_wake && line == LINE_J;
    endsequence
    sequence s_driving;
        st_reg.state == UWK_DRIVE_K && !usb_oe_n;
    endsequence
    property p_no_wake_active;
        st_reg.state == UWK_ACTIVE |=> usb_oe_n;
    endproperty
    a_no_wake_active: assert property (p_no_wake_active)
        else $error("wakeup driven outside suspend");
    property p_hold_off;
        st_reg.state == UWK_SUSPEND && !idle_wake |=>
            st_reg.state != UWK_DRIVE_K ##0 usb_oe_n;
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("wakeup started before 5 ms idle");
    property p_wake_now;
        s_wake_ready |=> s_driving;
    endproperty
    a_wake_now: assert property (p_wake_now)
        else $error("wakeup not started at once");
    property p_req_clear;
        st_reg.state == UWK_WAIT_RESUME && line == LINE_K &&
        st_reg.kcnt == TMR_W'(KDRIVE_CYC_P - 1 + ECHO_CYC) |=>
            !st_reg.wake_req && st_reg.state == UWK_ACTIVE;
    endproperty
    a_req_clear: assert property (p_req_clear)
        else $error("wakeup request not cleared on resume");
    property p_osc_stop;
        st_reg.bus_cfg[CFG_OSC_STOP] && st_reg.state == UWK_SUSPEND |=>
            usb_oe_n;
    endproperty
    a_osc_stop: assert property (p_osc_stop)
        else $error("wakeup while oscillator stopped");
    property p_mux_addr;
        st_reg.bus_cfg[CFG_MUX] && !(ale_s && !st_reg.ale_q) |=>
            $stable(bus_addr);
    endproperty
    a_mux_addr: assert property (p_mux_addr)
        else $error("separate address used in multiplexed mode");
    property p_sep_addr;
        !st_reg.bus_cfg[CFG_MUX] |=> bus_addr == $past(sep_s);
    endproperty
    a_sep_addr: assert property (p_sep_addr)
        else $error("address strobe used in separate mode");
    property p_dma8;
        dma_valid && !$past(st_reg.bus_cfg[CFG_DMA16]) |->
            dma_data[15:8] == BYTE_ZERO;
    endproperty
    a_dma8: assert property (p_dma8)
        else $error("upper byte used in eight-bit dma");
    property p_suspend_entry;
        st_reg.state == UWK_ACTIVE && idle_susp && !bus_reset_evt |=>
            st_reg.state == UWK_SUSPEND && st_reg.int_status[IS_SUSPEND];
    endproperty
    a_suspend_entry: assert property (p_suspend_entry)
        else $error("suspend not entered after 3 ms idle");
    property p_resume_clear;
        (st_reg.state == UWK_SUSPEND && line != LINE_J) || bus_reset_evt |=>
            !st_reg.int_status[IS_SUSPEND];
    endproperty
    a_resume_clear: assert property (p_resume_clear)
        else $error("suspend status kept after resume");
    property p_k_length;
        $rose(usb_oe_n) |->
            $past(st_reg.kcnt) == TMR_W'(KDRIVE_CYC_P - 1);
    endproperty
    a_k_length: assert property (p_k_length)
        else $error("K drive ended at wrong length");

endmodule
`default_nettype wire

// ===== verif/uwk_host_model.sv
// Purpose : usb host port model on the far side of the line
// Assumes : the device drives the line only while usb_oe_n is low
// Notes   : answers a remote wakeup with a resume K of its own
`timescale 1ns/1ps
`default_nettype none
module uwk_host_model
    import uwk_pkg::*;
#(
    parameter int RESUME_CYC = 40
) (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // bench control
    input  wire logic [1:0] host_line,
    input  wire logic       answer,
    // device side of the line
    input  wire logic       dev_oe_n,
    input  wire logic       dev_dp,
    input  wire logic       dev_dm,
    output logic            dp_in,
    output logic            dm_in
);
    logic oe_n_d;
    int   k_left;

    // resume K once the device lets go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_d <= 1'h1;
            k_left <= 0;
        end else begin
            oe_n_d <= dev_oe_n;
            if (answer && dev_oe_n && !oe_n_d) begin
                k_left <= RESUME_CYC;
            end else if (k_left > 0) begin
                k_left <= k_left - 1;
            end
        end
    end

    // host owns the line after release
    always_comb begin
        if (!dev_oe_n) begin
            {dp_in, dm_in} = {dev_dp, dev_dm};
        end else if (k_left > 0) begin
            {dp_in, dm_in} = LINE_K;
        end else begin
            {dp_in, dm_in} = host_line;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Purpose : self-checking bench of the remote wakeup block
// Assumes : shortened line times, host model on the usb line
// Notes   : expected register values kept in a small bench model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb
    import uwk_pkg::*;
;
    localparam int SUS = 300;
    localparam int WK  = 500;
    localparam int KD  = 50;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, ad, sep, upper, bus_addr;
    logic [31:0] pwdata, prdata, rdat, exp_stat, exp_en;
    logic        rerr, dp_in, dm_in, dp_out, dm_out, oe_n;
    logic        ale, dma_strobe, dma_valid, irq;
    logic [15:0] dma_data;
    logic [1:0]  host_line;
    logic [15:0] dq[$];
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc, n, t;
    int          seed = 60;
    logic [7:0]  regs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};

    uwk_remote_wakeup_ctrl #(.SUSPEND_CYC_P(SUS), .WAKE_CYC_P(WK),
        .KDRIVE_CYC_P(KD)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .usb_dp_in(dp_in),
        .usb_dm_in(dm_in), .usb_dp_out(dp_out), .usb_dm_out(dm_out),
        .usb_oe_n(oe_n), .ale(ale), .ad_lines(ad),
        .separate_address_inputs(sep), .upper_data_byte_lines(upper),
        .dma_strobe(dma_strobe), .bus_addr(bus_addr), .dma_data(dma_data),
        .dma_valid(dma_valid), .interrupt_request_out(irq));

    uwk_host_model HOST (
        .pclk(pclk), .presetn(presetn), .host_line(host_line),
        .answer(1'h1), .dev_oe_n(oe_n), .dev_dp(dp_out), .dev_dm(dm_out),
        .dp_in(dp_in), .dm_in(dm_in));

    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
        end
    end

    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // apb transfer: setup, then access until pready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (pready !== 1'h1) begin
            `CHK(pready, 1'h1)
            stop_test();
        end
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'h1, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'h0, WORD_ZERO);
        `CHK(rdat, e)
        `CHK(rerr, (a > ADDR_BUS_CFG))
    endtask

    task automatic irq_chk();
        repeat (2) @(posedge pclk);
        `CHK(irq, |(exp_stat & exp_en))
    endtask

    function automatic logic flag(int w);
        case (w)
            0: return irq;
            1: return ~oe_n;
            default: return dma_valid;
        endcase
    endfunction

    // bounded wait for irq, line drive or dma pulse
    task automatic wait_for(input int w, input int lim);
        n = 0;
        while (flag(w) !== 1'h1) begin
            @(posedge pclk);
            n++;
            if (n > lim) begin
                `CHK(1'h1, 1'h0)
                stop_test();
            end
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, ale, dma_strobe} = 6'h00;
        paddr = 8'h00;
        pwdata = WORD_ZERO;
        {ad, sep, upper} = 24'h000000;
        host_line = LINE_J;
        exp_stat = WORD_ZERO;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        foreach (regs[i]) rd_chk(regs[i], WORD_ZERO);
        wr(ADDR_INT_STATUS, 32'h0000_00FF);
        wr(ADDR_DEV_STATE, 32'h0000_0010);
        rd_chk(ADDR_DEV_STATE, WORD_ZERO);
        exp_en = 32'h0000_0040;
        wr(ADDR_INT_ENABLE, exp_en);
        wait_for(0, SUS + 50);
        `CHK(cyc >= SUS && cyc <= SUS + 8, 1'h1)
        exp_stat = 32'h0000_0040;
        rd_chk(ADDR_INT_STATUS, exp_stat);
        rd_chk(ADDR_DEV_STATE, 32'h0000_0001);
        exp_en = WORD_ZERO;
        wr(ADDR_INT_ENABLE, exp_en);
        irq_chk();
        exp_en = 32'h0000_0030;
        wr(ADDR_INT_ENABLE, exp_en);
        // software asks for wakeup while still early
        wr(ADDR_DEV_STATE, 32'h0000_0010);
        rd_chk(ADDR_DEV_STATE, 32'h0000_0011);
        `CHK(oe_n, 1'h1)
        wait_for(1, WK);
        `CHK(cyc >= WK && cyc <= WK + 8, 1'h1)
        `CHK({dp_out, dm_out}, LINE_K)
        n = 0;
        while (oe_n === 1'h0 && n < 4 * KD) begin
            @(posedge pclk);
            n++;
        end
        `CHK(n, KD)
        wait_for(0, 400);
        exp_stat = 32'h0000_0010;
        rd_chk(ADDR_DEV_STATE, WORD_ZERO);
        rd_chk(ADDR_INT_STATUS, exp_stat);
        wr(ADDR_INT_CLEAR, exp_stat);
        exp_stat = WORD_ZERO;
        irq_chk();
        exp_en = 32'h0000_0040;
        wr(ADDR_INT_ENABLE, exp_en);
        wr(ADDR_BUS_CFG, 32'h0000_0004);
        wait_for(0, 2 * SUS);
        exp_en = 32'h0000_0010;
        wr(ADDR_INT_ENABLE, exp_en);
        wr(ADDR_DEV_STATE, 32'h0000_0010);
        t = 0;
        repeat (WK + 100) begin
            @(posedge pclk);
            if (oe_n === 1'h0) t++;
        end
        `CHK(t, 0)
        wr(ADDR_BUS_CFG, WORD_ZERO);
        wait_for(1, 4);
        rd_chk(ADDR_DEV_STATE, 32'h0000_0013);
        wait_for(0, 400);
        exp_stat = 32'h0000_0010;
        rd_chk(ADDR_DEV_STATE, WORD_ZERO);
        rd_chk(ADDR_INT_STATUS, exp_stat);
        wr(ADDR_INT_CLEAR, exp_stat);
        exp_stat = WORD_ZERO;
        exp_en = 32'h0000_0040;
        wr(ADDR_INT_ENABLE, exp_en);
        wait_for(0, 2 * SUS);
        host_line <= LINE_SE0;
        repeat (700) @(posedge pclk);
        host_line <= LINE_J;
        exp_stat = 32'h0000_0020;
        rd_chk(ADDR_INT_STATUS, exp_stat);
        rd_chk(ADDR_DEV_STATE, WORD_ZERO);
        irq_chk();
        exp_en = 32'h0000_0020;
        wr(ADDR_INT_ENABLE, exp_en);
        irq_chk();
        wr(ADDR_INT_CLEAR, exp_stat);
        exp_stat = WORD_ZERO;
        irq_chk();
        // every bus and dma width mode, twice, with random pin values
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_BUS_CFG, {30'h0, i[1:0]});
            ad    <= 8'($random(seed));
            sep   <= 8'($random(seed));
            upper <= 8'($random(seed));
            ale   <= 1'h0;
            dma_strobe <= 1'h0;
            repeat (4) @(posedge pclk);
            ale <= 1'h1;
            repeat (5) @(posedge pclk);
            t = i[0] ? ad : sep;
            `CHK(bus_addr, t[7:0])
            sep <= 8'($random(seed));
            ale <= 1'h0;
            repeat (5) @(posedge pclk);
            if (!i[0]) t = sep;
            `CHK(bus_addr, t[7:0])
            dq.push_back({i[1] ? upper : 8'h00, ad});
            dma_strobe <= 1'h1;
            wait_for(2, 8);
            `CHK(dma_data, dq.pop_front())
        end
        stop_test();
    end
endmodule
`default_nettype wire
